// ### src/spc_regs.svh
// register offsets, field positions, reset values and timing counts
// assumes an apb slave with byte addresses and one 32-bit word per register
`ifndef SPC_REGS_SVH
`define SPC_REGS_SVH

// ==========================================================
// register map
`define SPC_OFF_CTRL    8'h00
`define SPC_OFF_PCTL    8'h04
`define SPC_OFF_PCNTA   8'h08
`define SPC_OFF_PCNTB   8'h0C
`define SPC_OFF_BKPT    8'h10
`define SPC_OFF_STAT    8'h14
`define SPC_CTRL_SE     0
`define SPC_CTRL_BE     1
`define SPC_CTRL_EE     2
`define SPC_PCTL_CNT    2
`define SPC_BKPT_EN     30
`define SPC_RESET_PC    30'h0000_0000

// ==========================================================
// exception vectors and unit latencies
`define SPC_VEC_PROG    16'h0700
`define SPC_VEC_TRACE   16'h0D00
`define SPC_VEC_FPAST   16'h0E00
`define SPC_VEC_PERF    16'h0F00
`define SPC_VEC_BKPT    16'h1300
`define SPC_VEC_SMI     16'h1400
`define SPC_MUL_STAGES  3
`define SPC_FP_STAGES   3
`define SPC_ROB_DEPTH   8
`define SPC_NUM_UNITS   6

`endif

// ### src/spc_pkg.sv
// types shared by the pipeline control core and its exception recogniser
// assumes spc_regs.svh is on the include path
package spc_pkg;
  `include "spc_regs.svh"

  typedef enum logic [2:0] {
    K_ALU  = 3'h0, K_MUL = 3'h1, K_DIV = 3'h2, K_SPR = 3'h3,
    K_FP   = 3'h4, K_FDIV = 3'h5, K_BR = 3'h6, K_RFI = 3'h7
  } spc_kind_type;

  typedef enum logic [1:0] {CS_RUN = 2'b01, CS_RDR = 2'b10} spc_cs_type;

  typedef struct packed {
    logic         v;
    logic         dw;
    spc_kind_type kind;
    logic [29:0]  pc;
  } spc_ins_type;

  typedef struct packed {
    logic         v;
    logic         done;
    logic         exc;
    logic         mis;
    logic         dw;
    spc_kind_type kind;
    logic [29:0]  pc;
    logic [29:0]  tgt;
  } spc_rob_type;

  typedef struct packed {
    logic s1;
    logic s2;
    logic pend;
  } spc_exc_st_type;

  typedef struct packed {
    spc_cs_type   cs;
    logic [2:0]   ctrl;
    logic [2:0]   pctl;
    logic [31:0]  cnta;
    logic [31:0]  cntb;
    logic [1:0]   pmsb;
    logic [30:0]  bkpt;
    logic [15:0]  lvec;
    logic [29:0]  fpc;
    spc_ins_type  f;
    spc_ins_type  d;
    spc_ins_type  s;
    spc_rob_type [`SPC_ROB_DEPTH-1:0] reorder_buffer;
    logic [2:0]   hd;
    logic [2:0]   tl;
    logic [3:0]   cnt;
    logic         bmul;
    logic         bfd;
    logic [2:0]   dtag;
    logic [2:0]   ftag;
    logic         wbp;
    logic [2:0]   wbt;
    logic [31:0]  rdata;
    logic         rdy;
    logic         err;
    logic         icr;
    logic         iss_v;
    logic [2:0]   iss_tag;
    spc_kind_type iss_kind;
    logic         cmp_v;
    logic [2:0]   cmp_tag;
    logic         cmp_upd;
    logic         wb_v;
    logic [2:0]   wb_tag;
    logic         flush;
    logic         exc_v;
    logic [15:0]  exc_vec;
  } spc_core_st_type;
endpackage

// ### src/spc_exc_if.sv
// completion-head view handed to the exception recogniser, and its verdict
// assumes both ends run on pclk
`timescale 1ns/10ps
`default_nettype none
interface spc_exc_if;
  import spc_pkg::*;
  logic         hv;       // head entry valid
  logic         hdone;    // head finished execution
  logic         hexc;     // head carries unit exception
  spc_kind_type hkind;    // head class
  logic [29:0]  hpc;      // head word address
  logic         se;       // single_step_trace_enable
  logic         be;       // branch_trace_enable
  logic         ee;       // external_interrupt_enable
  logic         bk_en;    // breakpoint enable
  logic [29:0]  bk_addr;  // instruction_breakpoint_address
  logic [1:0]   neg;      // counter went negative, one cycle
  logic [1:0]   pen;      // perf_monitor_control enables
  logic         arm;      // completion may act this cycle
  logic         pre;      // take exception before completing head
  logic         trc;      // take trace after completing head
  logic [15:0]  vec;      // chosen vector
  logic         pend;     // perf condition held
  modport core (output hv, hdone, hexc, hkind, hpc, se, be, ee, bk_en, bk_addr, neg, pen, arm,
                input pre, trc, vec, pend);
  modport exc  (input hv, hdone, hexc, hkind, hpc, se, be, ee, bk_en, bk_addr, neg, pen, arm,
                output pre, trc, vec, pend);
endinterface
`default_nettype wire

// ### src/spc_exc.sv
// exception recogniser: picks the vector for the instruction at completion
// assumes the smi pin is asynchronous and the core acts on pre/trc in the same cycle
`timescale 1ns/10ps
`default_nettype none
`include "spc_regs.svh"
module spc_exc (
  input wire logic pclk,     // processor clock
  input wire logic presetn,  // async reset, active low
  input wire logic pclk_en,  // freezes state when low
  input wire logic smi_n,    // system management pin, active low
  spc_exc_if.exc   x         // head view and verdict
);
  import spc_pkg::*;
  spc_exc_st_type q;
  spc_exc_st_type n;
  logic           system_management_interrupt_input;
  logic           perf;
  logic           hit;

  // ==========================================================
  // recognition
  // asynchronous causes beat the breakpoint, which beats unit exceptions
  always_comb begin
    n      = q;
    n.s1   = ~smi_n;
    n.s2   = q.s1;
    system_management_interrupt_input    = x.ee & q.s2;
    perf   = x.ee & q.pend;
    hit    = x.hv & x.bk_en & (x.hpc == x.bk_addr);
    x.pre  = x.arm & (system_management_interrupt_input | perf | hit | (x.hv & x.hdone & x.hexc));
    x.trc  = x.arm & ~x.pre & x.hv & x.hdone &
             ((x.se & (x.hkind != K_RFI)) | (x.be & (x.hkind == K_BR)));
    // only listed vectors appear; assist and reserved slots never do
    if (system_management_interrupt_input)
      x.vec = `SPC_VEC_SMI;
    else if (perf)
      x.vec = `SPC_VEC_PERF;
    else if (hit)
      x.vec = `SPC_VEC_BKPT;
    else if (x.pre)
      x.vec = `SPC_VEC_PROG;
    else
      x.vec = `SPC_VEC_TRACE;
    // a new negative crossing wins over the clear by the take
    n.pend = (q.pend & ~(x.pre & ~system_management_interrupt_input & perf)) | (|(x.neg & x.pen));
    x.pend = q.pend;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      q <= '0;
    else if (pclk_en)
      q <= n;
  end

  // ==========================================================
  // checks
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_perf_pend_set: assert property ((|(x.neg & x.pen)) && pclk_en |=> q.pend)
    else $error("perf condition not held");
  a_perf_masked: assert property (!x.ee |-> !(x.pre && x.vec == `SPC_VEC_PERF))
    else $error("perf taken while masked");
endmodule
`default_nettype wire

// ### src/spc_core.sv
// superscalar pipeline control: fetch, decode, dispatch, reorder, completion
// assumes icache and execution units are logic on pclk; smi_n is an async pin
//
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "spc_regs.svh"
module spc_core (
  input  wire logic                  pclk,        // processor clock, 125 MHz
  input  wire logic                  presetn,     // async reset, active low
  input  wire logic                  pclk_en,     // freezes all state when low
  input  wire logic                  psel,        // apb select
  input  wire logic                  penable,     // apb access phase
  input  wire logic                  pwrite,      // apb write
  input  wire logic [7:0]            paddr,       // apb byte address
  input  wire logic [31:0]           pwdata,      // apb write data
  output logic      [31:0]           prdata,      // apb read data
  output logic                       pready,      // apb ready
  output logic                       pslverr,     // apb unmapped address
  input  wire logic                  smi_n,       // system management pin, low active
  input  wire logic                  ic_valid,    // icache word valid
  input  wire spc_pkg::spc_kind_type ic_kind,     // class of fetched word
  input  wire logic                  ic_direct,   // result bypasses rename
  output logic                       ic_ready,    // decode queue has room
  output logic      [29:0]           fetch_addr,  // next fetch word address
  output logic                       iss_valid,   // issue to a unit, pulse
  output logic      [2:0]            iss_tag,     // reorder tag of issue
  output spc_pkg::spc_kind_type      iss_kind,    // unit class of issue
  input  wire logic                  fin_valid,   // unit finished, pulse
  input  wire logic [2:0]            fin_tag,     // tag of finished entry
  input  wire logic                  fin_exc,     // unit saw an exception
  input  wire logic                  fin_mis,     // branch was mispredicted
  input  wire logic [29:0]           fin_tgt,     // correct branch path
  output logic                       cmp_valid,   // instruction completed
  output logic      [2:0]            cmp_tag,     // tag completed
  output logic                       cmp_upd,     // flags/count/return update
  output logic                       wb_valid,    // rename to arch write
  output logic      [2:0]            wb_tag,      // tag written back
  output logic                       flush,       // cancel all in flight
  output logic                       exc_valid,   // exception taken, pulse
  output logic      [15:0]           exc_vec      // vector offset taken
);
  import spc_pkg::*;
  spc_core_st_type q;
  spc_core_st_type n;
  spc_exc_if       x ();
  spc_rob_type     hd;
  logic            wr;
  logic            unit_ok;
  logic            issue;
  logic            dmove;
  logic            fmove;
  logic            accept;
  logic            cmpl;
  logic            redir;
  logic            take;

  spc_exc u_exc (
    .pclk    (pclk),
    .presetn (presetn),
    .pclk_en (pclk_en),
    .smi_n   (smi_n),
    .x       (x)
  );

  // ==========================================================
  // head view for the recogniser
  assign hd        = q.reorder_buffer[q.hd];
  assign x.hv      = hd.v;
  assign x.hdone   = hd.done;
  assign x.hexc    = hd.exc;
  assign x.hkind   = hd.kind;
  assign x.hpc     = hd.pc;
  assign x.se      = q.ctrl[`SPC_CTRL_SE];
  assign x.be      = q.ctrl[`SPC_CTRL_BE];
  assign x.ee      = q.ctrl[`SPC_CTRL_EE];
  assign x.bk_en   = q.bkpt[`SPC_BKPT_EN];
  assign x.bk_addr = q.bkpt[29:0];
  assign x.pen     = q.pctl[1:0];
  assign x.arm     = (q.cs == CS_RUN);
  // crossings seen one cycle late, so the take path never loops back
  assign x.neg     = {q.cntb[31], q.cnta[31]} & ~q.pmsb;

  // ==========================================================
  // next state
  always_comb begin
    n         = q;
    n.iss_v   = 1'b0;
    n.cmp_v   = 1'b0;
    n.cmp_upd = 1'b0;
    n.wb_v    = 1'b0;
    n.flush   = 1'b0;
    n.exc_v   = 1'b0;
    n.cs      = CS_RUN;
    n.pmsb    = {q.cntb[31], q.cnta[31]};

    // apb: answer one cycle after setup so read data is a flop
    n.rdy     = psel & ~penable;
    n.err     = 1'b0;
    n.rdata   = 32'h0000_0000;
    if (psel & ~penable) begin
      case (paddr)
        `SPC_OFF_CTRL:  n.rdata = {29'h0, q.ctrl};
        `SPC_OFF_PCTL:  n.rdata = {29'h0, q.pctl};
        `SPC_OFF_PCNTA: n.rdata = q.cnta;
        `SPC_OFF_PCNTB: n.rdata = q.cntb;
        `SPC_OFF_BKPT:  n.rdata = {1'b0, q.bkpt};
        `SPC_OFF_STAT:  n.rdata = {11'h0, x.pend, q.cnt, q.lvec};
        default:        n.err   = 1'b1;
      endcase
    end
    wr = psel & penable & q.rdy & pwrite & ~q.err;

    // unit finish: mark done, record exception and branch path
    if (fin_valid && q.reorder_buffer[fin_tag].v && !q.reorder_buffer[fin_tag].done) begin
      n.reorder_buffer[fin_tag].done = 1'b1;
      n.reorder_buffer[fin_tag].exc  = fin_exc;
      n.reorder_buffer[fin_tag].mis  = fin_mis;
      n.reorder_buffer[fin_tag].tgt  = fin_tgt;
    end
    // an iterating divide frees its unit when it reports back or on a flush
    if (fin_valid && fin_tag == q.dtag)
      n.bmul = 1'b0;
    if (fin_valid && fin_tag == q.ftag)
      n.bfd = 1'b0;

    // completion: oldest entry only, so exceptions stay precise
    take  = x.pre | x.trc;
    cmpl  = x.arm & hd.v & hd.done & ~x.pre;
    redir = cmpl & hd.mis & ~x.trc;
    n.wb_v   = q.wbp;
    n.wb_tag = q.wbt;
    n.wbp    = 1'b0;
    if (cmpl) begin
      n.reorder_buffer[q.hd].v = 1'b0;
      n.hd          = q.hd + 3'h1;
      n.cmp_v       = 1'b1;
      n.cmp_tag     = q.hd;
      n.cmp_upd     = (hd.kind == K_BR) | (hd.kind == K_SPR);
      // special results go at completion, direct ones get no writeback, the rest a cycle later
      n.wbp         = ~hd.dw & ~n.cmp_upd;
      n.wbt         = q.hd;
    end

    // dispatch: multiplier blocked only by a divide, spr ops never
    case (q.s.kind)
      K_MUL, K_DIV: unit_ok = ~q.bmul;
      K_FP, K_FDIV: unit_ok = ~q.bfd;
      default:      unit_ok = 1'b1;
    endcase
    issue = x.arm & q.s.v & unit_ok & (q.cnt != 4'(`SPC_ROB_DEPTH));
    if (issue) begin
      n.reorder_buffer[q.tl] = '{v: 1'b1, done: 1'b0, exc: 1'b0, mis: 1'b0, dw: q.s.dw,
                      kind: q.s.kind, pc: q.s.pc, tgt: 30'h0};
      n.tl        = q.tl + 3'h1;
      n.iss_v     = 1'b1;
      n.iss_tag   = q.tl;
      n.iss_kind  = q.s.kind;
      if (q.s.kind == K_DIV) begin
        n.bmul = 1'b1;
        n.dtag = q.tl;
      end
      if (q.s.kind == K_FDIV) begin
        n.bfd  = 1'b1;
        n.ftag = q.tl;
      end
    end
    n.cnt = q.cnt + {3'h0, issue} - {3'h0, cmpl};

    // stage advance: each slot moves when the one ahead frees
    dmove = q.d.v & (~q.s.v | issue);
    fmove = q.f.v & (~q.d.v | dmove);
    if (issue)
      n.s.v = 1'b0;
    if (dmove)
      n.s = q.d;
    if (dmove)
      n.d.v = 1'b0;
    if (fmove)
      n.d = q.f;
    if (fmove)
      n.f.v = 1'b0;
    // fetch: fill the decode queue and step the fetch address
    accept = ic_valid & q.icr;
    if (accept) begin
      n.f   = '{v: 1'b1, dw: ic_direct, kind: ic_kind, pc: q.fpc};
      n.fpc = q.fpc + 30'h1;
    end

    // perf counters: a counts completions, b counts issues
    if (q.pctl[`SPC_PCTL_CNT]) begin
      n.cnta = q.cnta + {31'h0, cmpl};
      n.cntb = q.cntb + {31'h0, issue};
    end

    // software writes win over counting; status is read-only
    if (wr) begin
      case (paddr)
        `SPC_OFF_CTRL:  n.ctrl = pwdata[2:0];
        `SPC_OFF_PCTL:  n.pctl = pwdata[2:0];
        `SPC_OFF_PCNTA: n.cnta = pwdata;
        `SPC_OFF_PCNTB: n.cntb = pwdata;
        `SPC_OFF_BKPT:  n.bkpt = pwdata[30:0];
        default:        n.lvec = q.lvec;
      endcase
    end

    // flush: everything younger is gone and fetch restarts
    if (take | redir) begin
      n.f.v   = 1'b0;
      n.d.v   = 1'b0;
      n.s.v   = 1'b0;
      n.reorder_buffer   = '0;
      n.hd    = 3'h0;
      n.tl    = 3'h0;
      n.cnt   = 4'h0;
      n.bmul  = 1'b0;
      n.bfd   = 1'b0;
      n.iss_v = 1'b0;
      n.flush = 1'b1;
      n.cs    = CS_RDR;
      n.fpc   = take ? {16'h0, x.vec[15:2]} : hd.tgt;
    end
    // taking masks further async causes; hardware beats a same-cycle write
    if (take) begin
      n.exc_v               = 1'b1;
      n.exc_vec             = x.vec;
      n.lvec                = x.vec;
      n.ctrl[`SPC_CTRL_EE]  = 1'b0;
    end
    n.icr = ~n.f.v;
  end

  // ==========================================================
  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q     <= '0;
      q.cs  <= CS_RUN;
      q.fpc <= `SPC_RESET_PC;
    end else if (pclk_en) begin
      q <= n;
    end
  end

  // ==========================================================
  // outputs, all straight from the state register
  assign prdata     = q.rdata;
  assign pready     = q.rdy;
  assign pslverr    = q.err;
  assign ic_ready   = q.icr;
  assign fetch_addr = q.fpc;
  assign iss_valid  = q.iss_v;
  assign iss_tag    = q.iss_tag;
  assign iss_kind   = q.iss_kind;
  assign cmp_valid  = q.cmp_v;
  assign cmp_tag    = q.cmp_tag;
  assign cmp_upd    = q.cmp_upd;
  assign wb_valid   = q.wb_v;
  assign wb_tag     = q.wb_tag;
  assign flush      = q.flush;
  assign exc_valid  = q.exc_v;
  assign exc_vec    = q.exc_vec;

  // ==========================================================
  // checks
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_apb_one_wait: assert property (psel && !penable && pclk_en |=> pready)
    else $error("apb answer missing");
  a_apb_ready_pulse: assert property (pready && pclk_en |=> !pready)
    else $error("apb ready held");
  a_trace_take: assert property (x.trc && pclk_en |=>
    exc_valid && exc_vec == `SPC_VEC_TRACE && cmp_valid)
    else $error("trace not taken after completion");
  a_vec_legal: assert property (exc_valid |-> exc_vec inside
    {`SPC_VEC_PROG, `SPC_VEC_TRACE, `SPC_VEC_PERF, `SPC_VEC_BKPT, `SPC_VEC_SMI})
    else $error("illegal vector");
  a_bkpt_enable: assert property (exc_valid && !$past(exc_valid) &&
    exc_vec == `SPC_VEC_BKPT |-> $past(q.bkpt[`SPC_BKPT_EN]))
    else $error("breakpoint while disabled");
  a_smi_enable: assert property (exc_valid && !$past(exc_valid) &&
    exc_vec == `SPC_VEC_SMI |-> $past(q.ctrl[`SPC_CTRL_EE]) && !q.ctrl[`SPC_CTRL_EE])
    else $error("smi taken while masked");
  a_flush_exc: assert property (exc_valid |-> flush && !iss_valid)
    else $error("exception without flush");
  a_flush_clear: assert property (flush |-> q.cnt == 4'h0 && !q.s.v && q.cs == CS_RDR)
    else $error("flush left work behind");
  a_div_block: assert property (iss_valid && iss_kind == K_DIV && !flush && pclk_en |=>
    !(iss_valid && (iss_kind == K_MUL || iss_kind == K_DIV)))
    else $error("multiplier issued during divide");
  a_wb_after_cmp: assert property (cmpl && q.wbp == 1'b0 && n.wbp && pclk_en |=>
    ##1 wb_valid)
    else $error("writeback missing");

  c_trace: cover property (exc_valid && exc_vec == `SPC_VEC_TRACE);
  c_mispredict: cover property (cmp_valid && flush && !exc_valid);
  c_div_spr: cover property (q.bmul && iss_valid && iss_kind == K_SPR);
  c_smi: cover property (exc_valid && exc_vec == `SPC_VEC_SMI);
endmodule
`default_nettype wire

// ### bench/spc_units_model.sv
// execution unit stand-in: finishes issued work in order after a delay
// assumes issue and flush pulses from the core on pclk
`timescale 1ns/10ps
`default_nettype none
module spc_units_model #(
  parameter logic [29:0] TGT = 30'h123  // correct branch path
) (
  input  wire logic                  pclk,       // processor clock
  input  wire logic                  presetn,    // async reset, active low
  input  wire logic                  iss_valid,  // issue pulse
  input  wire logic [2:0]            iss_tag,    // issued tag
  input  wire spc_pkg::spc_kind_type iss_kind,   // issued class
  input  wire logic                  flush,      // drop pending work
  input  wire logic [3:0]            lat,        // finish delay
  input  wire logic                  mis_on,     // mispredict branches
  input  wire logic                  exc_on,     // report unit exception
  output logic                       fin_valid,  // finish pulse
  output logic      [2:0]            fin_tag,    // finished tag
  output logic                       fin_exc,    // exception seen
  output logic                       fin_mis,    // mispredicted
  output logic      [29:0]           fin_tgt     // correct path
);
  import spc_pkg::*;
  int q[$];
  int wait_n;
  assign fin_tgt = TGT;
  // ==========================================================
  // qualifiers toggle when idle so stale values never pass
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q.delete();
      wait_n <= 0;
      {fin_valid, fin_tag, fin_exc, fin_mis} <= 6'h0;
    end else begin
      fin_valid <= 1'b0;
      {fin_tag, fin_exc, fin_mis} <= ~{fin_tag, fin_exc, fin_mis};
      if (iss_valid) q.push_back(((iss_kind == K_BR) ? 8 : 0) + iss_tag);
      if (flush) begin
        q.delete();
        wait_n <= 0;
      end else if (q.size() > 0 && wait_n >= lat) begin
        fin_valid <= 1'b1;  // result written, finish reported
        fin_tag   <= q[0][2:0];
        fin_mis   <= mis_on && q[0][3];
        fin_exc   <= exc_on;  // unit keeps going, reports exception
        void'(q.pop_front());
        wait_n    <= 0;
      end else if (q.size() > 0) wait_n <= wait_n + 1;
    end
  end
endmodule
`default_nettype wire

// ### bench/superscalar_pipeline_ctrl_tb.sv
// self-checking bench: apb, icache stream, exception scenarios
// assumes spc_core and spc_units_model compiled before
`timescale 1ns/10ps
`default_nettype none
module superscalar_pipeline_ctrl_tb;
  import spc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, smi_n, ic_valid, ic_direct, mis_on, exc_on, err;
  logic pready, pslverr, ic_ready, iss_valid, fin_valid, fin_exc, fin_mis, cmp_valid, cmp_upd;
  logic wb_valid, flush, exc_valid, wb_due, wb_skip, upd;
  logic [2:0] iss_tag, fin_tag, cmp_tag, wb_tag, wb_exp;
  logic [3:0] lat;
  logic [7:0] paddr;
  logic [15:0] exc_vec;
  logic [29:0] fetch_addr, fin_tgt;
  logic [31:0] pwdata, prdata, rd;
  spc_kind_type ic_kind, iss_kind;
  int n_fail, n_tests, n_cmp, n_exc, c0, i, e;
  int fq[$], exp_q[$];

  spc_core DUT (.pclk, .presetn, .pclk_en(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .smi_n, .ic_valid, .ic_kind, .ic_direct, .ic_ready, .fetch_addr, .iss_valid,
    .iss_tag, .iss_kind, .fin_valid, .fin_tag, .fin_exc, .fin_mis, .fin_tgt, .cmp_valid, .cmp_tag,
    .cmp_upd, .wb_valid, .wb_tag, .flush, .exc_valid, .exc_vec);
  spc_units_model units (.pclk, .presetn, .iss_valid, .iss_tag, .iss_kind, .flush, .lat, .mis_on,
    .exc_on, .fin_valid, .fin_tag, .fin_exc, .fin_mis, .fin_tgt);

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // ==========================================================
  // report helpers
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [47:0] g, input logic [47:0] x);
    n_tests++;
    if (g !== x) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, g, x);
    end
  endtask
  task automatic tmo(input int n);
    if (n >= 200) begin
      n_fail++;
      summarize();
    end
  endtask

  // ==========================================================
  // apb master: setup, access until pready, then one idle edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 200);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    tmo(k);
    @(posedge pclk);
  endtask
  // icache word held until taken; caller lowers ic_valid
  task automatic feed(input spc_kind_type k, input logic d);
    int n;
    ic_valid <= 1'b1;
    ic_kind <= k;
    ic_direct <= d;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (ic_ready !== 1'b1 && n < 200);
    tmo(n);
    fq.push_back(8 * d + int'(k));
  endtask
  task automatic expect_exc(input logic [15:0] v);
    for (i = 0; i < 200 && exc_valid !== 1'b1; i++) @(posedge pclk);
    tmo(i);
    chk(exc_vec, v);
    @(posedge pclk);
  endtask

  // ==========================================================
  // reference model: in-order completion, writeback, issue class
  always @(posedge pclk) begin
    if (presetn && !wb_skip) chk({wb_valid, wb_valid ? wb_tag : 3'h0}, {wb_due, wb_exp});
    wb_due = 1'b0;
    wb_exp = 3'h0;
    wb_skip = flush;
    if (cmp_valid) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 255;
      upd = e[5:3] inside {K_BR, K_SPR};
      chk(cmp_tag, e[2:0]);
      chk(cmp_upd, upd);
      wb_due = !e[6] && !upd;
      wb_exp = wb_due ? e[2:0] : 3'h0;
      n_cmp++;
    end
    if (iss_valid) begin
      e = (fq.size() > 0) ? fq.pop_front() : 0;
      exp_q.push_back(e * 8 + iss_tag);
      chk(iss_kind, e[2:0]);
    end
    if (flush) begin
      exp_q.delete();
      fq.delete();
    end
    if (exc_valid) begin
      n_exc++;
      chk(exc_vec inside {16'h0700, 16'h0D00, 16'h0F00, 16'h1300, 16'h1400}, 1'b1);
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, ic_valid, ic_direct, mis_on, exc_on, wb_due, wb_skip} = 10'h0;
    {paddr, pwdata, lat, wb_exp} = 47'h0;
    smi_n = 1'b1;
    ic_kind = K_ALU;
    void'($urandom(78521));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0); // reset value
    apb(1'b1, 8'h10, 32'h4000_0ABC);
    apb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h4000_0ABC);
    apb(1'b1, 8'h10, 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    chk({err, rd}, {1'b1, 32'h0}); // unmapped
    $display("test registers done");
    // random stream, every class but return-from-interrupt
    for (c0 = 0; c0 < 14; c0++) begin
      lat <= 4'($urandom % 4);
      feed(spc_kind_type'($urandom % 7), 1'($urandom));
    end
    ic_valid <= 1'b0;
    for (i = 0; i < 200 && n_cmp < 14; i++) @(posedge pclk);
    tmo(i);
    chk(n_cmp, 14);
    $display("test stream done");
    // return-from-interrupt not traced, next one is
    apb(1'b1, 8'h00, 32'h1);
    c0 = n_cmp;
    feed(K_RFI, 1'b0);
    feed(K_ALU, 1'b0);
    ic_valid <= 1'b0;
    expect_exc(16'h0D00);
    chk(n_cmp - c0, 2);
    apb(1'b1, 8'h00, 32'h2);
    feed(K_BR, 1'b0);
    ic_valid <= 1'b0;
    expect_exc(16'h0D00);
    $display("test trace done");
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b1, 8'h10, {2'b01, fetch_addr});
    feed(K_ALU, 1'b0);
    ic_valid <= 1'b0;
    expect_exc(16'h1300);
    apb(1'b1, 8'h10, 32'h0);
    exc_on <= 1'b1;
    feed(K_MUL, 1'b0);
    ic_valid <= 1'b0;
    expect_exc(16'h0700);
    exc_on <= 1'b0;
    apb(1'b1, 8'h00, 32'h4);
    smi_n <= 1'b0;
    feed(K_ALU, 1'b0);
    ic_valid <= 1'b0;
    expect_exc(16'h1400);
    smi_n <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0); // enable dropped on take
    $display("test breakpoint, unit, smi done");
    // perf condition held while external enable is clear
    apb(1'b1, 8'h04, 32'h5);
    apb(1'b1, 8'h08, 32'h7FFF_FFFF);
    c0 = n_exc;
    feed(K_ALU, 1'b0);
    ic_valid <= 1'b0;
    repeat (20) @(posedge pclk);
    apb(1'b0, 8'h14, 32'h0);
    chk({rd[20], n_exc - c0}, 1'b1 << 32);
    // held condition is taken right after the enable lands, so watch before feeding
    apb(1'b1, 8'h00, 32'h4);
    expect_exc(16'h0F00);
    feed(K_ALU, 1'b0);
    ic_valid <= 1'b0;
    mis_on <= 1'b1;
    feed(K_BR, 1'b0);
    ic_valid <= 1'b0;
    for (i = 0; i < 200 && flush !== 1'b1; i++) @(posedge pclk);
    tmo(i);
    @(posedge pclk);
    chk(fetch_addr, 30'h123);
    $display("test perf and mispredict done");
    summarize();
  end
endmodule
`default_nettype wire
